// ---- system_memory_map_decoder.v ----
// Shared address decoder and memory-region access policy.
// Behaviour
// - Addresses 0x0 to 0x1FFFFFFF are the code region, code and data.
// - Vector table fetches start at address zero.
// - Second region is unmapped, every access refused, no bit-band alias.
// - Peripheral region holds registers and refuses instruction fetches.
// - External RAM region allows instruction fetches.
// - Private bus region routes to core-internal registers.
// - 128 KB supervisory ROM decodes from address zero.
// - SRAM up to 288 KB decodes inside code region.
// - Application flash up to 1 MB in 256 KB sectors.
// - Emulated EEPROM and supervisory flash sectors decode separately.
// - After secure mode, supervisory flash writes are blocked.
// - Flash reads use a 128-bit wide path.
// - Flash programming works on whole 512-byte rows.
// - Flash reads in both modes; writes refused in ultra-low-power.
// - Top of code region is a 128 MB execute-in-place window.
// - SRAM retention whole or per selected 32 KB block.
// - Fuse array of 1024 bits, low 512 for system use.
// - Fuse bits start 0, become 1 when programmed, and revert only when reset clears the model.
// - ROM executes only for the secondary core in context 0.
// - System function requests raise the secondary core's NMI.
`include "memory_map_consts.vh"
module system_memory_map_decoder (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Master request.
    input wire req,
    input wire [31:0] addr,
    input wire write,
    input wire fetch,
    input wire vector_fetch,
    input wire [1:0] master_id,
    input wire [2:0] prot_ctx,
    // System state.
    input wire secure_mode,
    input wire ulp_mode,
    // SRAM retention control.
    input wire retain_all,
    input wire [`SRAM_BLOCKS-1:0] retain_sel,
    // System function requests.
    input wire sysfn_req_main,
    input wire sysfn_req_sec,
    input wire sysfn_req_dap,
    // Fuse programming.
    input wire fuse_prog,
    input wire fuse_user_only,
    input wire [`FUSE_IDX_W-1:0] fuse_prog_idx,
    input wire [`FUSE_IDX_W-1:0] fuse_rd_idx,
    // Decode answer.
    output reg ack_q,
    output reg err_q,
    output reg [3:0] target_q,
    output reg [31:0] offset_q,
    output reg to_core_q,
    output reg [1:0] aflash_sector_q,
    output reg [3:0] sram_block_q,
    output reg [31:0] flash_line_q,
    output reg [31:0] flash_row_q,
    output reg flash_write_q,
    // Retention.
    output reg [`SRAM_BLOCKS-1:0] retain_q,
    // Secondary core non-maskable interrupt.
    output reg nmi_q,
    // Fuse read and refusal.
    output reg fuse_bit_q,
    output reg fuse_refused_q
);
    // ==========================================================
    // Region decode.
    wire [3:0] nib = addr[31:28];
    wire in_code = (nib >= `CODE_NIB_LO) && (nib <= `CODE_NIB_HI);
    wire in_sreg = (nib >= `SRAM_NIB_LO) && (nib <= `SRAM_NIB_HI);
    wire in_peri = (nib >= `PERI_NIB_LO) && (nib <= `PERI_NIB_HI);
    wire in_xram = (nib >= `XRAM_NIB_LO) && (nib <= `XRAM_NIB_HI);
    wire in_ppb = (addr >= `PPB_BASE) && (addr <= `PPB_LAST);
    wire in_dev = (addr >= `DEV_BASE);
    wire in_rom = (addr <= `ROM_LAST);
    wire in_sram = (addr >= `SRAM_BASE) && (addr <= `SRAM_LAST);
    wire in_af = (addr >= `AFLASH_BASE) && (addr <= `AFLASH_LAST);
    wire in_ef = (addr >= `EFLASH_BASE) && (addr <= `EFLASH_LAST);
    wire in_sf = (addr >= `SUPERVISORY_FLASH_BASE) && (addr <= `SUPERVISORY_FLASH_LAST);
    wire in_xip = (addr >= `XIP_BASE) && (addr <= `XIP_LAST);
    wire is_flash = in_af || in_ef || in_sf;
    // ==========================================================
    // Target select and base.
    reg [3:0] tgt;
    reg [31:0] base;
    always @* begin
        tgt = `TGT_NONE;
        base = 32'h00000000;
        if (in_code) begin
            if (in_rom) begin
                tgt = `TGT_ROM;
                base = `ROM_BASE;
            end else if (in_sram) begin
                tgt = `TGT_SRAM;
                base = `SRAM_BASE;
            end else if (in_af) begin
                tgt = `TGT_AFLASH;
                base = `AFLASH_BASE;
            end else if (in_ef) begin
                tgt = `TGT_EFLASH;
                base = `EFLASH_BASE;
            end else if (in_sf) begin
                tgt = `TGT_SUPERVISORY_FLASH;
                base = `SUPERVISORY_FLASH_BASE;
            end else if (in_xip) begin
                tgt = `TGT_XIP;
                base = `XIP_BASE;
            end
        end else if (in_peri) begin
            tgt = `TGT_PERI;
        end else if (in_xram) begin
            tgt = `TGT_XRAM;
        end else if (in_ppb) begin
            tgt = `TGT_PPB;
            base = `PPB_BASE;
        end else if (in_dev) begin
            tgt = `TGT_DEV;
        end
        // The SRAM region carries no memory, so it decodes as unmapped.
        if (in_sreg) begin
            tgt = `TGT_NONE;
        end
    end
    // ==========================================================
    // Access policy.
    wire exec_region = in_code || in_sreg || in_xram;
    wire rom_ok = (master_id == `MASTER_SEC) && (prot_ctx == 3'h0);
    // Vector fetches must land in the ROM, which decodes from address zero.
    wire vec_bad = vector_fetch && (addr < `VECTOR_BASE + 32'h0 ? 1'b1 :
                   !in_rom);
    wire rom_bad = fetch && (tgt == `TGT_ROM) && !rom_ok && !vector_fetch;
    wire fetch_bad = fetch && (!exec_region || in_peri);
    wire unmapped = (tgt == `TGT_NONE);
    wire sf_lock = write && in_sf && secure_mode;
    wire ulp_lock = write && is_flash && ulp_mode;
    wire rom_wr = write && (tgt == `TGT_ROM);
    wire bad = unmapped || fetch_bad || rom_bad || vec_bad ||
               sf_lock || ulp_lock || rom_wr;
    wire [31:0] off = addr - base;
    // ==========================================================
    // Registered answer, one cycle after the request.
    always @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            target_q <= `TGT_NONE;
            offset_q <= 32'h00000000;
            to_core_q <= 1'b0;
            aflash_sector_q <= 2'h0;
            sram_block_q <= 4'h0;
            flash_line_q <= 32'h00000000;
            flash_row_q <= 32'h00000000;
            flash_write_q <= 1'b0;
        end else begin
            ack_q <= req && !bad;
            err_q <= req && bad;
            if (req) begin
                target_q <= bad ? `TGT_NONE : tgt;
                offset_q <= bad ? 32'h00000000 : off;
                to_core_q <= !bad && in_ppb;
                aflash_sector_q <= off[`AFLASH_SECTOR_LSB+1:
                                       `AFLASH_SECTOR_LSB];
                sram_block_q <= off[`SRAM_BLOCK_LSB+3:`SRAM_BLOCK_LSB];
                // Reads fetch a full line, so the low four bits drop.
                flash_line_q <= {off[31:4], 4'h0};
                // Writes always address a whole row.
                flash_row_q <= {off[31:`ROW_LSB], 9'h000};
                flash_write_q <= !bad && write && is_flash;
            end else begin
                to_core_q <= 1'b0;
                flash_write_q <= 1'b0;
            end
        end
    end
    // ==========================================================
    // SRAM retention.
    always @(posedge clk) begin
        if (reset) begin
            retain_q <= {`SRAM_BLOCKS{1'b0}};
        end else begin
            retain_q <= retain_all ? {`SRAM_BLOCKS{1'b1}} :
                        retain_sel;
        end
    end
    // ==========================================================
    // System function requests.
    // Any request raises the NMI on the next cycle; the secondary core runs it.
    always @(posedge clk) begin
        if (reset) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= sysfn_req_main || sysfn_req_sec ||
                     sysfn_req_dap;
        end
    end
    // ==========================================================
    // Fuse array.
    wire fuse_rd;
    wire fuse_ref;
    fuse_array u_fuse (
        .clk(clk),
        .reset(reset),
        .prog(fuse_prog),
        .user_only(fuse_user_only),
        .prog_idx(fuse_prog_idx),
        .rd_idx(fuse_rd_idx),
        .rd_bit_q(fuse_rd),
        .prog_refused_q(fuse_ref)
    );
    always @(posedge clk) begin
        if (reset) begin
            fuse_bit_q <= 1'b0;
            fuse_refused_q <= 1'b0;
        end else begin
            fuse_bit_q <= fuse_rd;
            fuse_refused_q <= fuse_ref;
        end
    end
endmodule // system_memory_map_decoder

// ---- memory_map_consts.vh ----
// Address map, region windows and memory geometry constants.
`ifndef MEMORY_MAP_CONSTS_VH
`define MEMORY_MAP_CONSTS_VH
// ==========================================================
// Architectural regions; code to external RAM compared on address bits [31:28], private bus and device on the full address.
`define CODE_NIB_LO 4'h0
`define CODE_NIB_HI 4'h1
`define SRAM_NIB_LO 4'h2
`define SRAM_NIB_HI 4'h3
`define PERI_NIB_LO 4'h4
`define PERI_NIB_HI 4'h5
`define XRAM_NIB_LO 4'h6
`define XRAM_NIB_HI 4'h9
`define PPB_BASE 32'hE0000000
`define PPB_LAST 32'hE00FFFFF
`define DEV_BASE 32'hE0100000
// ==========================================================
// Internal memories.
`define ROM_BASE 32'h00000000
`define ROM_LAST 32'h0001FFFF
`define SRAM_BASE 32'h08000000
`define SRAM_LAST 32'h08047FFF
`define AFLASH_BASE 32'h10000000
`define AFLASH_LAST 32'h100FFFFF
`define EFLASH_BASE 32'h14000000
`define EFLASH_LAST 32'h14007FFF
`define SUPERVISORY_FLASH_BASE 32'h16000000
`define SUPERVISORY_FLASH_LAST 32'h16007FFF
`define XIP_BASE 32'h18000000
`define XIP_LAST 32'h1FFFFFFF
`define VECTOR_BASE 32'h00000000
// ==========================================================
// Geometry.
`define AFLASH_SECTOR_LSB 18
`define SRAM_BLOCK_LSB 15
`define SRAM_BLOCKS 9
`define ROW_LSB 9
`define FLASH_WIDTH 128
// ==========================================================
// Fuse array.
`define FUSE_BITS 1024
`define FUSE_IDX_W 10
`define FUSE_SYS_BITS 512
// ==========================================================
// Target select codes.
`define TGT_NONE 4'h0
`define TGT_ROM 4'h1
`define TGT_SRAM 4'h2
`define TGT_AFLASH 4'h3
`define TGT_EFLASH 4'h4
`define TGT_SUPERVISORY_FLASH 4'h5
`define TGT_XIP 4'h6
`define TGT_PERI 4'h7
`define TGT_XRAM 4'h8
`define TGT_PPB 4'h9
`define TGT_DEV 4'hA
`define MASTER_SEC 2'h1
`endif

// ---- fuse_array.v ----
// One-time-programmable fuse bits with a read port.
`include "memory_map_consts.vh"
module fuse_array (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Program request.
    input wire prog,
    input wire user_only,
    input wire [`FUSE_IDX_W-1:0] prog_idx,
    // Read port.
    input wire [`FUSE_IDX_W-1:0] rd_idx,
    output reg rd_bit_q,
    output reg prog_refused_q
);
    // ==========================================================
    // Storage.
    // Reset clears the model storage; real fuses keep their state.
    reg [`FUSE_BITS-1:0] fuse_q;
    wire sys_idx = (prog_idx < `FUSE_SYS_BITS);
    genvar i;
    generate
        for (i = 0; i < `FUSE_BITS; i = i + 1) begin : g_fuse
            always @(posedge clk) begin
                if (reset) begin
                    fuse_q[i] <= 1'b0;
                end else if (prog && !(user_only && sys_idx) &&
                             prog_idx == i) begin
                    fuse_q[i] <= 1'b1;
                end
            end
        end
    endgenerate
    always @(posedge clk) begin
        if (reset) begin
            rd_bit_q <= 1'b0;
            prog_refused_q <= 1'b0;
        end else begin
            rd_bit_q <= fuse_q[rd_idx];
            prog_refused_q <= prog && user_only && sys_idx;
        end
    end
endmodule // fuse_array

// ---- decoder_checker_asserts.sv ----
// Concurrent checks on the memory map decoder ports.
`include "memory_map_consts.vh"
module decoder_checker (
    // Requests and system state.
    input wire clk,
    input wire reset,
    input wire req,
    input wire [31:0] addr,
    input wire write,
    input wire fetch,
    input wire vector_fetch,
    input wire [1:0] master_id,
    input wire [2:0] prot_ctx,
    input wire secure_mode,
    input wire ulp_mode,
    input wire sysfn_req_main,
    input wire sysfn_req_sec,
    input wire sysfn_req_dap,
    input wire fuse_prog,
    input wire fuse_user_only,
    input wire [`FUSE_IDX_W-1:0] fuse_prog_idx,
    // Decoder answers.
    input wire ack_q,
    input wire err_q,
    input wire [3:0] target_q,
    input wire to_core_q,
    input wire flash_write_q,
    input wire nmi_q,
    input wire fuse_refused_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Helpers.
    wire any_sysfn = sysfn_req_main | sysfn_req_sec | sysfn_req_dap;
    wire in_ppb = addr >= `PPB_BASE && addr <= `PPB_LAST;
    wire in_sfl = addr >= `SUPERVISORY_FLASH_BASE && addr <= `SUPERVISORY_FLASH_LAST;
    sequence s_rom_denied;
        req && fetch && !vector_fetch && addr <= `ROM_LAST
            && !(master_id == `MASTER_SEC && prot_ctx == 3'h0);
    endsequence
    sequence s_fuse_bad;
        fuse_prog && fuse_user_only && fuse_prog_idx < 10'h200;
    endsequence
    // ==========================================================
    // Assertions.
    a_answer_once: assert property (req |=> ack_q != err_q)
        else $error("request not answered exactly once");
    a_periph_no_fetch: assert property (
        req && fetch && addr[31:29] == 3'h2 |=> err_q && target_q == 4'h0)
        else $error("peripheral fetch not refused");
    a_ppb_to_core: assert property (
        req && !fetch && in_ppb |=> ack_q && to_core_q && target_q == `TGT_PPB)
        else $error("private bus access not routed to core");
    a_ulp_no_write: assert property (
        req && write && ulp_mode && addr[31:28] == 4'h1 && addr < `XIP_BASE
        |=> err_q && !flash_write_q)
        else $error("flash write accepted in low-power mode");
    a_supervisory_flash_locked: assert property (
        req && write && secure_mode && in_sfl |=> err_q)
        else $error("locked flash write accepted");
    a_rom_exec_gate: assert property (s_rom_denied |=> err_q)
        else $error("rom fetch by wrong master accepted");
    a_nmi_follows: assert property (1 |=> nmi_q == $past(any_sysfn))
        else $error("nmi does not follow request");
    a_fuse_refuse: assert property (s_fuse_bad |=> ##1 fuse_refused_q)
        else $error("system fuse programming not refused");
endmodule // decoder_checker
bind system_memory_map_decoder decoder_checker checker_i (.*);

// ---- bus_master_model.sv ----
// Bus master model that issues one decode request at a time.
module bus_master_model (
    // Clock.
    input wire clk,
    // Request toward the decoder.
    output logic req,
    output logic [31:0] addr,
    output logic write,
    output logic fetch,
    output logic vector_fetch,
    output logic [1:0] master_id,
    output logic [2:0] prot_ctx
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {req, addr, write, fetch, vector_fetch, master_id, prot_ctx} = '0;
    end
    // Released address and kind lines show the inverse, so stale values never look valid.
    task automatic issue(input logic [31:0] a, input logic [2:0] kind,
        input logic [1:0] mid, input logic [2:0] ctx);
        @(negedge clk);
        {write, fetch, vector_fetch} = kind;
        {req, addr, master_id, prot_ctx} = {1'b1, a, mid, ctx};
        @(negedge clk);
        {req, addr} = {1'b0, ~a};
        {write, fetch, vector_fetch} = ~kind;
    endtask
endmodule // bus_master_model

// ---- system_memory_map_decoder_tb.sv ----
// Self-checking bench for the memory map decoder.
`include "memory_map_consts.vh"
module system_memory_map_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] RD = 3'h0, WR = 3'h4, FE = 3'h2, VF = 3'h3;
    logic clk, reset, req, write, fetch, vector_fetch, secure_mode, ulp_mode;
    logic retain_all, fuse_prog, fuse_user_only;
    logic [31:0] addr;
    logic [1:0] master_id;
    logic [2:0] prot_ctx, sysfn;
    logic [8:0] retain_sel;
    logic [9:0] fuse_prog_idx, fuse_rd_idx;
    wire ack_q, err_q, to_core_q, flash_write_q, nmi_q, fuse_bit_q;
    wire fuse_refused_q;
    wire [3:0] target_q, sram_block_q;
    wire [1:0] aflash_sector_q;
    wire [31:0] offset_q, flash_line_q, flash_row_q;
    wire [8:0] retain_q;
    int n_mismatch = 0;
    int cmp_count = 0;
    bus_master_model master (.*);
    system_memory_map_decoder dut (.*, .sysfn_req_main(sysfn[0]),
        .sysfn_req_sec(sysfn[1]), .sysfn_req_dap(sysfn[2]));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================================
    // Shared tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A target of none means the request must be refused.
    task automatic access(input logic [31:0] a, input logic [2:0] kind,
        input logic [3:0] tgt, input logic [31:0] off,
        input logic [1:0] mid = 2'h0, input logic [2:0] ctx = 3'h0);
        master.issue(a, kind, mid, ctx);
        chk(ack_q, tgt != `TGT_NONE);
        chk(err_q, tgt == `TGT_NONE);
        chk(target_q, tgt);
        chk(offset_q, off);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_regions;
        access(32'h10040217, RD, `TGT_AFLASH, 32'h40217);
        chk(aflash_sector_q, 32'h1);
        chk(flash_line_q, 32'h40210);
        chk(flash_row_q, 32'h40200);
        access(32'h0001FFFF, RD, `TGT_ROM, 32'h1FFFF);
        access(32'h00020000, RD, `TGT_NONE, 32'h0);
        access(32'h08047FFF, RD, `TGT_SRAM, 32'h47FFF);
        chk(sram_block_q, 32'h8);
        access(32'h14000010, RD, `TGT_EFLASH, 32'h10);
        access(32'h16007FFF, RD, `TGT_SUPERVISORY_FLASH, 32'h7FFF);
        access(32'h1FFFFFFC, FE, `TGT_XIP, 32'h7FFFFFC);
        access(32'h20000000, RD, `TGT_NONE, 32'h0);
        access(32'h5FFFFFF0, RD, `TGT_PERI, 32'h5FFFFFF0);
        access(32'h40000000, FE, `TGT_NONE, 32'h0);
        access(32'h9FFFFFF0, FE, `TGT_XRAM, 32'h9FFFFFF0);
        access(32'hA0000000, RD, `TGT_NONE, 32'h0);
        access(32'hE0000100, WR, `TGT_PPB, 32'h100);
        chk(to_core_q, 1'b1);
        access(32'hE0100000, RD, `TGT_DEV, 32'hE0100000);
    endtask
    task automatic t_exec;
        access(32'h0, VF, `TGT_ROM, 32'h0);
        access(32'h100, FE, `TGT_ROM, 32'h100, 2'h1);
        access(32'h100, FE, `TGT_NONE, 32'h0, 2'h0);
        access(32'h100, FE, `TGT_NONE, 32'h0, 2'h1, 3'h1);
        access(32'h10000000, VF, `TGT_NONE, 32'h0);
    endtask
    task automatic t_flash;
        access(32'h10000200, WR, `TGT_AFLASH, 32'h200);
        chk(flash_write_q, 1'b1);
        ulp_mode = 1'b1;
        access(32'h10000200, RD, `TGT_AFLASH, 32'h200);
        access(32'h10000200, WR, `TGT_NONE, 32'h0);
        ulp_mode = 1'b0;
        secure_mode = 1'b1;
        access(32'h16000000, WR, `TGT_NONE, 32'h0);
        access(32'h16000000, RD, `TGT_SUPERVISORY_FLASH, 32'h0);
        secure_mode = 1'b0;
    endtask
    task automatic t_sysfn_retain;
        for (int i = 0; i < 3; i++) begin
            sysfn = 3'h1 << i;
            @(negedge clk);
            sysfn = 3'h0;
            chk(nmi_q, 1'b1);
            @(negedge clk);
            chk(nmi_q, 1'b0);
        end
        retain_sel = 9'h0A5;
        @(negedge clk);
        chk(retain_q, 9'h0A5);
        retain_all = 1'b1;
        @(negedge clk);
        chk(retain_q, 9'h1FF);
    endtask
    // Programs one fuse, checks the expected refusal, then reads the bit back.
    task automatic t_fuse(input logic [9:0] idx, input logic refuse);
        fuse_rd_idx = idx;
        {fuse_prog_idx, fuse_prog} = {idx, 1'b1};
        @(negedge clk);
        fuse_prog = 1'b0;
        @(negedge clk);
        chk(fuse_refused_q, refuse);
        repeat (3) @(negedge clk);
        chk(fuse_bit_q, !refuse);
    endtask
    // ==========================================================
    // Main sequence and watchdog.
    initial begin
        reset = 1'b1;
        {secure_mode, ulp_mode, retain_all, sysfn, retain_sel} = '0;
        {fuse_prog, fuse_prog_idx, fuse_rd_idx} = '0;
        fuse_user_only = 1'b1;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        t_regions();
        t_exec();
        t_flash();
        t_sysfn_retain();
        t_fuse(10'h258, 1'b0);
        t_fuse(10'h1FF, 1'b1);
        fuse_rd_idx = 10'h258;
        repeat (3) @(negedge clk);
        chk(fuse_bit_q, 1'b1);
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule // system_memory_map_decoder_tb
